/* File: core/clk_wake_timer.sv */
// Counts the wake-up time the PHY is given after clock-disable deasserts
`timescale 1ns/1ps
module clk_wake_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic [3:0] cycles,
  output logic done
);
  logic [3:0] count_r;
  logic busy_r;
  // Load on start, count down, report the final cycle
  assign done = busy_r && (count_r == 4'h0);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_r <= 4'h0;
      busy_r <= 1'b0;
    end else if (start) begin
      count_r <= cycles;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      if (count_r == 4'h0) begin
        busy_r <= 1'b0;
      end else begin
        count_r <= count_r - 4'h1;
      end
    end
  end
endmodule

/* File: core/dfi_write_latency_timing_regs.sv */
// Write-latency timing register with its DFI write-enable and clock-wake timing
`timescale 1ns/1ps
`include "wrlat_defs.svh"
module dfi_write_latency_timing_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Settings from neighbouring controller registers
  input wire logic [3:0] wrlat_adj,
  input wire logic reg_dimm_enable,
  // Controller command side
  input wire logic ctl_write_cmd,
  input wire logic ctl_clk_disable,
  // DFI side
  output logic dfi_wrdata_en,
  output logic dfi_dram_clk_disable,
  output logic [3:0] phy_rdlat,
  output logic clk_enable_ready
);
  // ==========================================================
  // Register state
  wrlat_pkg::field_t path_adj_r;
  wrlat_pkg::field_t rdlat_r;
  wrlat_pkg::field_t clken_r;
  wrlat_pkg::field_t wrlat_r;
  wrlat_pkg::field_t wrlat_nxt;
  wrlat_pkg::clk_state_e clk_state_r;
  wrlat_pkg::clk_state_e clk_state_nxt;
  logic ack_r;
  logic [31:0] rd_word;
  logic [31:0] wr_mask;
  logic [31:0] cur_word;
  logic [31:0] new_word;
  logic hit;
  logic wr_take;
  logic rd_take;
  logic wren_delayed;
  logic wake_start;
  logic wake_done;

  // Byte-enable expansion, used for the write merge
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Sum widened so an unsupported small sum cannot wrap to a large latency
  function automatic logic [3:0] eff_latency(input logic [3:0] p, input logic [3:0] a, input logic d);
    logic [5:0] s;
    s = {2'b00, p} + {2'b00, a} + {5'b00000, d};
    eff_latency = (s < `WLT_LAT_OFFSET) ? 4'h0 : 4'((s - `WLT_LAT_OFFSET));
  endfunction

  // ==========================================================
  // Bus decode: one wait cycle, then the answer
  assign hit = (avs_address == `WLT_OFFSET);
  // A write lands only at the edge where waitrequest is seen low, never a cycle early
  assign wr_take = avs_write && ack_r;
  assign rd_take = avs_read && !ack_r;
  assign cur_word = {4'h0, path_adj_r, 4'h0, wrlat_r, 4'h0, rdlat_r, 4'h0, clken_r};
  assign rd_word = hit ? (cur_word & `WLT_READ_MASK) : `WLT_UNMAPPED_DATA;
  assign wr_mask = lane_mask(avs_byteenable) & `WLT_WRITE_MASK;
  assign new_word = (cur_word & ~wr_mask) | (avs_writedata & wr_mask);

  assign wrlat_nxt = eff_latency(path_adj_r, wrlat_adj, reg_dimm_enable);

  // Handshake and register writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      avs_readdata <= `WLT_UNMAPPED_DATA;
      path_adj_r <= `WLT_FIELD_RESET;
      rdlat_r <= `WLT_FIELD_RESET;
      clken_r <= `WLT_FIELD_RESET;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      if (rd_take) begin
        avs_readdata <= rd_word;
      end
      if (wr_take && hit) begin
        path_adj_r <= new_word[`WLT_PATH_HI:`WLT_PATH_LO];
        rdlat_r <= new_word[`WLT_RDLAT_HI:`WLT_RDLAT_LO];
        clken_r <= new_word[`WLT_CLKEN_HI:`WLT_CLKEN_LO];
      end
    end
  end

  // Waitrequest drops for exactly the answer cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_r);
    end
  end

  // ==========================================================
  // Latency register; resets to zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrlat_r <= `WLT_FIELD_RESET;
    end else begin
      wrlat_r <= wrlat_nxt;
    end
  end

  wrlat_delay_line #(
    .DEPTH(16)
  ) u_wren (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .latency(wrlat_r),
    .strobe_in(ctl_write_cmd),
    .strobe_out(wren_delayed)
  );

  // DFI enable and read latency both pass through one register stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dfi_wrdata_en <= 1'b0;
      phy_rdlat <= `WLT_FIELD_RESET;
    end else begin
      dfi_wrdata_en <= wren_delayed;
      phy_rdlat <= rdlat_r;
    end
  end

  // ==========================================================
  // Clock-disable sequencing
  assign wake_start = (clk_state_r == wrlat_pkg::CLK_OFF) && !ctl_clk_disable;
  always_comb begin
    clk_state_nxt = clk_state_r;
    unique case (clk_state_r)
      wrlat_pkg::CLK_ON: begin
        if (ctl_clk_disable) begin
          clk_state_nxt = wrlat_pkg::CLK_OFF;
        end
      end
      wrlat_pkg::CLK_OFF: begin
        if (!ctl_clk_disable) begin
          clk_state_nxt = wrlat_pkg::CLK_WAKE;
        end
      end
      wrlat_pkg::CLK_WAKE: begin
        if (wake_done) begin
          clk_state_nxt = wrlat_pkg::CLK_ON;
        end
      end
      default: begin
        clk_state_nxt = wrlat_pkg::CLK_ON;
      end
    endcase
  end

  clk_wake_timer u_wake (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(wake_start),
    .cycles(clken_r),
    .done(wake_done)
  );

  // State and DFI clock-disable output
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_state_r <= wrlat_pkg::CLK_ON;
      dfi_dram_clk_disable <= 1'b0;
      clk_enable_ready <= 1'b1;
    end else begin
      clk_state_r <= clk_state_nxt;
      dfi_dram_clk_disable <= ctl_clk_disable;
      clk_enable_ready <= (clk_state_nxt == wrlat_pkg::CLK_ON);
    end
  end
endmodule

/* File: core/wrlat_defs.svh */
// Offsets, field positions and reset values for the write-latency timing register
`ifndef WRLAT_DEFS_SVH
`define WRLAT_DEFS_SVH
`define WLT_OFFSET 8'h84
`define WLT_PATH_HI 27
`define WLT_PATH_LO 24
`define WLT_WRLAT_HI 19
`define WLT_WRLAT_LO 16
`define WLT_RDLAT_HI 11
`define WLT_RDLAT_LO 8
`define WLT_CLKEN_HI 3
`define WLT_CLKEN_LO 0
`define WLT_FIELD_RESET 4'h0
`define WLT_LAT_OFFSET 6'h03
`define WLT_READ_MASK 32'h0f0f_0f0f
`define WLT_WRITE_MASK 32'h0f00_0f0f
`define WLT_UNMAPPED_DATA 32'h0000_0000
`endif

/* File: core/wrlat_delay_line.sv */
// Shift line that places write-data-enable a programmable number of cycles after a write command
`timescale 1ns/1ps
module wrlat_delay_line #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic [3:0] latency,
  input wire logic strobe_in,
  output logic strobe_out
);
  logic [DEPTH-1:0] pipe_r;
  logic [DEPTH-1:0] pipe_nxt;
  // Latency 0 means the enable comes with the command itself
  assign strobe_out = (latency == 4'h0) ? strobe_in : pipe_r[latency - 4'h1];
  assign pipe_nxt = {pipe_r[DEPTH-2:0], strobe_in};
  // Shift each cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pipe_r <= '0;
    end else begin
      pipe_r <= pipe_nxt;
    end
  end
endmodule

/* File: core/wrlat_pkg.sv */
// Types shared by the write-latency timing block
package wrlat_pkg;
  typedef logic [3:0] field_t;
  typedef enum logic [1:0] {
    CLK_ON = 2'b00,
    CLK_OFF = 2'b01,
    CLK_WAKE = 2'b10
  } clk_state_e;
endpackage

/* File: testbench/dfi_phy_model.sv */
// Behavioural DFI PHY that takes data beats and wakes its pads
`timescale 1ns/1ps
module dfi_phy_model (
  // Clock and DFI inputs
  input wire logic core_clk,
  input wire logic dfi_wrdata_en,
  input wire logic dfi_dram_clk_disable,
  // Observation
  output int wren_seen,
  output logic pads_on
);
  initial wren_seen = 0;
  always @(posedge core_clk) wren_seen <= wren_seen + int'(dfi_wrdata_en === 1'h1);
  // pads answer one cycle after clock-disable, inside any count
  always @(posedge core_clk) pads_on <= !dfi_dram_clk_disable;
endmodule

/* File: testbench/dfi_write_latency_timing_regs_tb_top.sv */
// Self-checking bench for the write-latency timing register
`timescale 1ns/1ps
module dfi_write_latency_timing_regs_tb_top;
  logic core_clk = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic reg_dimm_enable = 1'h0, ctl_write_cmd = 1'h0, ctl_clk_disable = 1'h0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, w;
  logic [3:0] avs_byteenable = 4'h0, wrlat_adj = 4'h0, phy_rdlat, p, r, c, be, l;
  logic avs_waitrequest, dfi_wrdata_en, dfi_dram_clk_disable, clk_enable_ready, pads_on;
  int failures = 0, check_count = 0, wren_seen, k;
  dfi_write_latency_timing_regs dut_u (.*);
  dfi_phy_model phy_u (.*);
  initial forever #10 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Avalon transfer held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    {avs_address, avs_writedata, avs_byteenable} <= {a, d, be};
    {avs_read, avs_write} <= {!wr, wr};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 20);
    q = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
    if (avs_waitrequest !== 1'h0) begin
      failures++;
      end_of_test();
    end
  endtask
  // Sums under three are unsupported, so they clamp to zero
  function automatic logic [3:0] lat_of(input logic [4:0] s);
    return s < 5'h03 ? 4'h0 : 4'(s - 5'h03);
  endfunction
  initial begin
    void'($urandom(32'hd06a));
    {p, r, c} = 12'h0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 10; i++) begin
      // adjust sum kept at three or more
      wrlat_adj <= 4'(3 + $urandom % 5);
      reg_dimm_enable <= 1'($urandom);
      be = i == 0 ? 4'h0 : 4'($urandom);
      w = $urandom;
      w[27:24] = 4'($urandom % 6);
      p = be[3] ? w[27:24] : p;
      r = be[1] ? w[11:8] : r;
      c = be[0] ? w[3:0] : c;
      bus(1'h1, 8'h84, w);
      bus(1'h1, 8'h88, ~w);
      bus(1'h0, 8'h88, w);
      chk(q, 32'h0);
      bus(1'h0, 8'h84, w);
      l = lat_of(5'(p) + 5'(wrlat_adj) + 5'(reg_dimm_enable));
      chk(q, {4'h0, p, 4'h0, l, 4'h0, r, 4'h0, c});
      chk(phy_rdlat, r);
      // enable lands the latency after the command
      k = wren_seen;
      @(posedge core_clk);
      ctl_write_cmd <= 1'h1;
      @(posedge core_clk);
      ctl_write_cmd <= 1'h0;
      repeat (l) @(posedge core_clk);
      @(negedge core_clk);
      chk(dfi_wrdata_en, 1'h1);
      repeat (2) @(posedge core_clk);
      chk(wren_seen - k, 1);
      ctl_clk_disable <= 1'h1;
      repeat (3) @(posedge core_clk);
      ctl_clk_disable <= 1'h0;
      k = 0;
      do begin
        @(posedge core_clk);
        k++;
      end while (clk_enable_ready !== 1'h1 && k < 40);
      chk(k > c && k <= c + 6, 1'h1);
      chk(pads_on, 1'h1);
      if (k >= 40) begin
        end_of_test();
      end
    end
    end_of_test();
  end
endmodule

/* File: testbench/wrlat_props.sv */
// Port checks for the write-latency timing register
`timescale 1ns/1ps
module wrlat_props (
  // Clock, reset and controls
  input wire logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, reg_dimm_enable,
  input wire logic ctl_write_cmd, ctl_clk_disable, dfi_wrdata_en, dfi_dram_clk_disable, clk_enable_ready,
  // Buses and fields
  input wire logic [7:0] avs_address,
  input wire logic [31:0] avs_readdata,
  input wire logic [3:0] wrlat_adj, phy_rdlat
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Read answers; latency from the path field seen in the same word
  wire rd = avs_read && !avs_waitrequest;
  wire hit = avs_address == 8'h84;
  wire [4:0] sum = avs_readdata[27:24] + wrlat_adj + reg_dimm_enable;
  wire [3:0] lat = sum < 5'h03 ? 4'h0 : 4'(sum - 5'h03);
  a_reserved_zero: assert property (rd |-> (avs_readdata & 32'hf0f0_f0f0) == 32'h0)
    else $error("reserved bits set");
  a_unmapped_zero: assert property (rd && !hit |-> avs_readdata == 32'h0)
    else $error("unmapped read nonzero");
  a_lat_back: assert property (rd && hit |-> avs_readdata[19:16] == lat)
    else $error("latency field wrong");
  a_rdlat_port: assert property (rd && hit |-> avs_readdata[11:8] == phy_rdlat)
    else $error("read latency port differs");
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer late");
  a_wren_follows: assert property (ctl_write_cmd |-> ##[1:16] dfi_wrdata_en)
    else $error("write enable missing");
  a_clkdis_follow: assert property (dfi_dram_clk_disable == $past(ctl_clk_disable))
    else $error("clock disable shifted");
  a_wake_low: assert property ($fell(dfi_dram_clk_disable) |-> !clk_enable_ready)
    else $error("ready without wait");
endmodule
bind dfi_write_latency_timing_regs wrlat_props props_u (.*);
